// ### hw/mar_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef MAR_DEFS_SVH
`define MAR_DEFS_SVH
`define MAR_ADDR_W 6
`define MAR_OFF_RES0 6'h00
`define MAR_OFF_RES1 6'h04
`define MAR_OFF_RES2 6'h08
`define MAR_OFF_RES3 6'h0c
`define MAR_OFF_HI0 6'h10
`define MAR_OFF_LO0 6'h20
`define MAR_OFF_CTRL 6'h30
`define MAR_OFF_MAN 6'h34
`define MAR_OFF_STAT 6'h38
`define MAR_OFF_IEN 6'h3c
`define MAR_OFF_ICLR 6'h2c
`define MAR_OFF_PINS 6'h1c
`define MAR_CTRL_TEMP_IDX 0
`define MAR_CTRL_MAIN_PROT 1
`define MAR_CTRL_ALARM_OUT 2
`define MAR_CTRL_RST 3'h0
`define MAR_RES_MASK 16'hfff0
`define MAR_HI_RST 16'hffff
`define MAR_TEMP_HI_RST 16'h7fff
`define MAR_TEMP_LO_RST 16'h8000
`define MAR_LUT_BASE 8'h80
`define MAR_LUT_LAST 8'hc7
`define MAR_TEMP_MIN 8'hd8
`define MAR_TEMP_MAX 8'h66
`define MAR_FRAME_MS 20
`define MAR_CLK_MHZ 100
`define MAR_FRAME_CYC (`MAR_FRAME_MS * 1000 * `MAR_CLK_MHZ)
`endif

// ### hw/mar_pkg.sv
// types shared by the monitor block
package mar_pkg;
	typedef enum logic [1:0] {
		MAR_CH_TEMP,
		MAR_CH_SUPPLY,
		MAR_CH_ANA_A,
		MAR_CH_ANA_B
	} mar_chan_t;
	typedef enum {
		MAR_ST_WAIT,
		MAR_ST_LATCH,
		MAR_ST_CMP
	} mar_seq_t;
endpackage

// ### hw/mar_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module mar_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				q_o <= s3_r;
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/mar_cmp.sv
// limit compare for one channel result
`timescale 1ns/100ps
`default_nettype none
module mar_cmp (
	input wire logic [15:0] val_i,
	input wire logic [15:0] hi_i,
	input wire logic [15:0] lo_i,
	input wire logic signed_i,
	output logic over_o,
	output logic under_o
);
	// signed compare by flipping the sign bit
	wire [15:0] v = {val_i[15] ^ signed_i, val_i[14:0]};
	wire [15:0] h = {hi_i[15] ^ signed_i, hi_i[14:0]};
	wire [15:0] l = {lo_i[15] ^ signed_i, lo_i[14:0]};
	assign over_o = v > h;
	assign under_o = v < l;
endmodule
`default_nettype wire

// ### hw/mar_top.sv
// monitor, alarm, buffer and resistor control core with wishbone registers
`include "mar_defs.svh"
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - each channel result is 16 bits, 12 significant bits left-justified.
// - results refresh in fixed rotating order, each once per frame.
// - a per-channel done bit sets after every conversion.
// - results compare to high and low limits automatically, flags set promptly.
// - each monitored signal has its own interrupt enable.
// - first buffered output can assert while any high or low alarm flag is set.
// - two buffers copy logic inputs onto open-drain outputs.
// - resistor disable high turns both resistors off; defaults high.
// - write-protect pin low means never write protected; pulled high.
// - temperature is two's complement, 7fff top, 8000 bottom.
// - supply is unsigned, 100 microvolt per count.
// - analog inputs are unsigned, 38.147 microvolt per count.
// - resistor positions set independently; temperature mode uses a 2 degree table.
// - with temperature indexing off, positions come from manual registers.
// - writes other than interrupt clear blocked when main-protect bit and protect pin are high, or when byte lanes 0 and 1 are not both selected.
module mar_top import mar_pkg::*; #(
	parameter int FRAME_CYC = `MAR_FRAME_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [`MAR_ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [15:0] conv_data_i,
	input wire logic conv_valid_i,
	output logic [1:0] conv_chan_o,
	output logic conv_start_o,
	input wire logic buffer_in_a_i,
	input wire logic buffer_in_b_i,
	input wire logic write_protect_pin_i,
	input wire logic resistor_disable_in_i,
	output logic buffered_out_a_oe_o,
	output logic buffered_out_b_oe_o,
	output logic [7:0] res0_pos_o,
	output logic [7:0] res1_pos_o,
	output logic res_hiz_o,
	output logic [7:0] lut_addr_o,
	input wire logic [15:0] lut_data_i,
	output logic irq_o
);
	logic [15:0] res_r [4];
	logic [15:0] hi_r [4];
	logic [15:0] lo_r [4];
	logic [2:0] ctrl_r;
	logic [15:0] man_r;
	// status: [3:0] done, [7:4] high alarm, [11:8] low alarm
	logic [11:0] stat_r;
	logic [11:0] ien_r;
	logic [31:0] frame_cnt_r;
	logic [1:0] chan_r;
	mar_seq_t seq_r;
	logic [15:0] lat_r;
	logic pin_wp;
	logic pin_rdis;
	logic pin_ba;
	logic pin_bb;
	logic over_w;
	logic under_w;

	mar_sync #(.RST_VAL(1'b1)) u_wp (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(write_protect_pin_i),
		.q_o(pin_wp)
	);
	mar_sync #(.RST_VAL(1'b1)) u_rdis (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(resistor_disable_in_i),
		.q_o(pin_rdis)
	);
	mar_sync #(.RST_VAL(1'b0)) u_ba (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(buffer_in_a_i),
		.q_o(pin_ba)
	);
	mar_sync #(.RST_VAL(1'b0)) u_bb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(buffer_in_b_i),
		.q_o(pin_bb)
	);

	// bus decode
	wire req = cyc_i && stb_i && !ack_o;
	wire wr_prot = ctrl_r[`MAR_CTRL_MAIN_PROT] && pin_wp;
	wire wr_ok = req && we_i && sel_i[0] && sel_i[1] && !wr_prot;
	wire wr_hi = wr_ok && adr_i[5:4] == 2'b01 && adr_i[3:2] != 2'b11;
	wire wr_lo = wr_ok && adr_i[5:4] == 2'b10 && adr_i[3:2] != 2'b11;
	wire wr_ctrl = wr_ok && adr_i == `MAR_OFF_CTRL;
	wire wr_man = wr_ok && adr_i == `MAR_OFF_MAN;
	wire wr_ien = wr_ok && adr_i == `MAR_OFF_IEN;
	// interrupt clear is volatile, never protected
	wire wr_iclr = req && we_i && adr_i == `MAR_OFF_ICLR;
	wire [1:0] ai = adr_i[3:2];

	logic [31:0] rd_w;
	always_comb begin
		rd_w = 32'h0;
		case (adr_i)
			`MAR_OFF_RES0, `MAR_OFF_RES1, `MAR_OFF_RES2, `MAR_OFF_RES3: rd_w = {16'h0, res_r[ai]};
			`MAR_OFF_CTRL: rd_w = {29'h0, ctrl_r};
			`MAR_OFF_MAN: rd_w = {16'h0, man_r};
			`MAR_OFF_STAT: rd_w = {20'h0, stat_r};
			`MAR_OFF_IEN: rd_w = {20'h0, ien_r};
			`MAR_OFF_PINS: rd_w = {28'h0, pin_rdis, pin_wp, pin_bb, pin_ba};
			default: begin
				if (adr_i[5:4] == 2'b01 && ai != 2'b11) begin
					rd_w = {16'h0, hi_r[ai]};
				end else if (adr_i[5:4] == 2'b10 && ai != 2'b11) begin
					rd_w = {16'h0, lo_r[ai]};
				end
			end
		endcase
	end
	// channel 3 limits have no bus slot and keep their reset values

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= req;
			dat_o <= req ? rd_w : 32'h0;
		end
	end

	// conversion sequencer
	wire frame_tick = frame_cnt_r == 32'(FRAME_CYC / 4 - 1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_cnt_r <= 32'h0;
			chan_r <= 2'h0;
			seq_r <= MAR_ST_WAIT;
			lat_r <= 16'h0;
			conv_start_o <= 1'b0;
			conv_chan_o <= 2'h0;
		end else begin
			frame_cnt_r <= frame_tick ? 32'h0 : frame_cnt_r + 32'h1;
			conv_start_o <= 1'b0;
			case (seq_r)
				MAR_ST_WAIT: begin
					if (frame_tick) begin
						conv_start_o <= 1'b1;
						conv_chan_o <= chan_r;
						seq_r <= MAR_ST_LATCH;
					end
				end
				MAR_ST_LATCH: begin
					if (conv_valid_i) begin
						lat_r <= conv_data_i & `MAR_RES_MASK;
						seq_r <= MAR_ST_CMP;
					end
				end
				MAR_ST_CMP: begin
					chan_r <= chan_r + 2'h1;
					seq_r <= MAR_ST_WAIT;
				end
				default: seq_r <= MAR_ST_WAIT;
			endcase
		end
	end

	wire in_cmp = seq_r == MAR_ST_CMP;
	mar_cmp u_cmp (
		.val_i(lat_r),
		.hi_i(hi_r[chan_r]),
		.lo_i(lo_r[chan_r]),
		.signed_i(chan_r == MAR_CH_TEMP),
		.over_o(over_w),
		.under_o(under_w)
	);

	// per-channel storage
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			wire hit = in_cmp && chan_r == 2'(g);
			wire lim_sel = ai == 2'(g);
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					res_r[g] <= (g == 0) ? 16'h0 : 16'h0;
					hi_r[g] <= (g == 0) ? `MAR_TEMP_HI_RST : `MAR_HI_RST;
					lo_r[g] <= (g == 0) ? `MAR_TEMP_LO_RST : 16'h0;
					stat_r[g] <= 1'b0;
					stat_r[g+4] <= 1'b0;
					stat_r[g+8] <= 1'b0;
				end else begin
					if (hit) begin
						res_r[g] <= lat_r;
					end
					if (wr_hi && lim_sel) begin
						hi_r[g] <= dat_i[15:0];
					end
					if (wr_lo && lim_sel) begin
						lo_r[g] <= dat_i[15:0];
					end
					// set wins over clear
					stat_r[g] <= hit || (stat_r[g] && !(wr_iclr && dat_i[g]));
					stat_r[g+4] <= (hit && over_w) ||
						(stat_r[g+4] && !(wr_iclr && dat_i[g+4]));
					stat_r[g+8] <= (hit && under_w) ||
						(stat_r[g+8] && !(wr_iclr && dat_i[g+8]));
				end
			end
		end
	endgenerate

	// temperature index into the position table
	wire [7:0] t_int = res_r[0][15:8];
	wire t_low = $signed(t_int) < $signed(`MAR_TEMP_MIN);
	wire t_high = $signed(t_int) > $signed(`MAR_TEMP_MAX);
	wire [7:0] t_off = 8'(t_int - `MAR_TEMP_MIN);
	wire [7:0] lut_w = t_low ? `MAR_LUT_BASE :
		t_high ? `MAR_LUT_LAST : 8'(`MAR_LUT_BASE + {1'b0, t_off[7:1]});
	wire any_alarm = |stat_r[11:4];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `MAR_CTRL_RST;
			man_r <= 16'h0;
			ien_r <= 12'h0;
			irq_o <= 1'b0;
			lut_addr_o <= `MAR_LUT_BASE;
			res0_pos_o <= 8'h0;
			res1_pos_o <= 8'h0;
			res_hiz_o <= 1'b1;
			buffered_out_a_oe_o <= 1'b1;
			buffered_out_b_oe_o <= 1'b1;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= dat_i[2:0];
			end
			if (wr_man) begin
				man_r <= dat_i[15:0];
			end
			if (wr_ien) begin
				ien_r <= dat_i[11:0];
			end
			irq_o <= |(stat_r & ien_r);
			lut_addr_o <= lut_w;
			if (ctrl_r[`MAR_CTRL_TEMP_IDX]) begin
				res0_pos_o <= lut_data_i[7:0];
				res1_pos_o <= lut_data_i[15:8];
			end else begin
				res0_pos_o <= man_r[7:0];
				res1_pos_o <= man_r[15:8];
			end
			res_hiz_o <= pin_rdis;
			// oe low means the pin is pulled low
			// an enabled alarm pulls output a low
			buffered_out_a_oe_o <= pin_ba &&
				!(ctrl_r[`MAR_CTRL_ALARM_OUT] && any_alarm);
			buffered_out_b_oe_o <= pin_bb;
		end
	end

	property ack_one_p;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
	endproperty
	ack_once_a: assert property (ack_one_p) else $error("ack not single");
	prot_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && we_i && adr_i == `MAR_OFF_MAN && ctrl_r[`MAR_CTRL_MAIN_PROT] && pin_wp)
		|=> $stable(man_r)) else $error("protected write");
	wp_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!pin_wp && req && we_i && sel_i[1:0] == 2'b11 && adr_i == `MAR_OFF_MAN)
		|=> man_r == $past(dat_i[15:0])) else $error("write lost while unprotected");
	done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_cmp |=> stat_r[$past(chan_r)]) else $error("done not set");
	rot_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_cmp |=> chan_r == $past(chan_r) + 2'h1) else $error("rotation broken");
	res_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
		res_r[chan_r][3:0] == 4'h0) else $error("low bits not zero");
	hi_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(in_cmp && over_w) |=> stat_r[$past(chan_r) + 4]) else $error("high flag missing");
	hiz_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(pin_rdis) |=> res_hiz_o == $past(pin_rdis)) else $error("hiz lag");
	man_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_r[0] && $stable(man_r) |=> res0_pos_o == $past(man_r[7:0]))
		else $error("manual pos");
	buf_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(pin_bb) |=> buffered_out_b_oe_o) else $error("buffer b");
	irq_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ien_r == 12'h0) |=> !irq_o) else $error("irq with no enable");
	// conversion steps: result taken, then stored and flagged
	sequence conv_take_s;
		seq_r == MAR_ST_LATCH && conv_valid_i;
	endsequence
	sequence conv_store_s;
		in_cmp ##1 seq_r == MAR_ST_WAIT;
	endsequence
	property conv_step_p;
		@(posedge clk_i) disable iff (rst_i)
		conv_take_s |=> conv_store_s;
	endproperty
	conv_step_a: assert property (conv_step_p) else $error("conversion step skipped");
	mask_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_take_s |=> lat_r[3:0] == 4'h0)
		else $error("latched low bits not zero");
	res_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_cmp |=> res_r[$past(chan_r)] == $past(lat_r)) else $error("result not stored");
	start_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_start_o |=> !conv_start_o) else $error("start longer than one cycle");
	lo_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(in_cmp && under_w) |=> stat_r[$past(chan_r) + 8]) else $error("low flag missing");
	temp_sign_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(in_cmp && chan_r == MAR_CH_TEMP && lat_r[15] && !lo_r[0][15]) |-> under_w)
		else $error("signed compare lost");
	done_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_iclr && dat_i[0] && !(in_cmp && chan_r == 2'h0)) |=> !stat_r[0])
		else $error("done bit not cleared");
	alarm_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_iclr && dat_i[5] && !(in_cmp && chan_r == 2'h1 && over_w)) |=> !stat_r[5])
		else $error("alarm flag not cleared");
	irq_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(|(stat_r & ien_r)) |=> irq_o) else $error("irq missing");
	buf_a_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_r[`MAR_CTRL_ALARM_OUT] |=> buffered_out_a_oe_o == $past(pin_ba))
		else $error("buffer a");
	alarm_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctrl_r[`MAR_CTRL_ALARM_OUT] && any_alarm) |=> !buffered_out_a_oe_o)
		else $error("alarm not on output a");
	lut_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lut_addr_o >= `MAR_LUT_BASE && lut_addr_o <= `MAR_LUT_LAST)
		else $error("table address out of range");
	ack_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
endmodule
`default_nettype wire

// ### sim/mar_conv_model.sv
// converter and lookup-table model facing the monitor core
`timescale 1ns/100ps
`default_nettype none
module mar_conv_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic conv_start_i,
	input wire logic [1:0] conv_chan_i,
	input wire logic [63:0] vals_i,
	input wire logic [3:0] lat_i,
	input wire logic hold_i,
	input wire logic [7:0] lut_addr_i,
	output logic [15:0] lut_data_o,
	output logic [15:0] conv_data_o,
	output logic conv_valid_o
);
	logic busy_r;
	logic [3:0] cnt_r;
	assign lut_data_o = {~lut_addr_i, lut_addr_i};
	always_ff @(posedge clk_i) begin
		conv_valid_o <= 1'b0;
		// released data bus never repeats the last word
		conv_data_o <= ~conv_data_o;
		if (rst_i) begin
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
			conv_data_o <= 16'h5a5a;
		end else if (conv_start_i) begin
			busy_r <= 1'b1;
			cnt_r <= lat_i;
		end else if (busy_r && !hold_i && cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end else if (busy_r && !hold_i) begin
			busy_r <= 1'b0;
			conv_valid_o <= 1'b1;
			// raw word with low bits live, so the core must mask them
			conv_data_o <= vals_i[conv_chan_i * 16 +: 16];
		end
	end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the monitor core
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pa = 1, pb = 0, wp = 1, rz = 1;
	logic hold = 0, ack, cv, cs, oea, oeb, hiz, irq;
	logic [5:0] adr = 0;
	logic [31:0] wd = 0, rd, dat;
	logic [3:0] lat = 1;
	logic [3:0] sel = 4'hf;
	logic [63:0] vals = 64'h9abc_4321_2000_f600;
	logic [15:0] cd, ld;
	logic [7:0] r0, r1, la;
	logic [1:0] ch, c;
	int miscompares = 0, tests_run = 0;
	always #5 clk_i = ~clk_i;
	mar_top #(.FRAME_CYC(400)) mar_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(dat), .ack_o(ack),
		.conv_data_i(cd), .conv_valid_i(cv), .conv_chan_o(ch), .conv_start_o(cs),
		.buffer_in_a_i(pa), .buffer_in_b_i(pb), .write_protect_pin_i(wp),
		.resistor_disable_in_i(rz), .buffered_out_a_oe_o(oea), .buffered_out_b_oe_o(oeb),
		.res0_pos_o(r0), .res1_pos_o(r1), .res_hiz_o(hiz), .lut_addr_o(la), .lut_data_i(ld),
		.irq_o(irq));
	mar_conv_model mar_conv_model_inst (.clk_i(clk_i), .rst_i(rst_i), .conv_start_i(cs),
		.conv_chan_i(ch), .vals_i(vals), .lat_i(lat), .hold_i(hold), .lut_addr_i(la),
		.lut_data_o(ld), .conv_data_o(cd), .conv_valid_o(cv));
	task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= {16'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat;
		cyc <= 0;
		stb <= 0;
		if (n >= 20) miscompares++;
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [15:0] e, input string n);
		wb(0, a, 16'h0);
		`CHK(n, e, rd[15:0])
	endtask
	task automatic pollst(input logic [15:0] m);
		int n;
		n = 0;
		do begin
			wb(0, 6'h38, 16'h0);
			n++;
		end while ((rd[15:0] & m) !== m && n < 300);
		if ((rd[15:0] & m) !== m) miscompares++;
	endtask
	task automatic nextst(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (cs !== 1'b1 && n < 500);
	endtask
	task automatic t_reset;
		rdchk(6'h38, 16'h0, "stat");
		rdchk(6'h10, 16'h7fff, "temp_hi");
		rdchk(6'h20, 16'h8000, "temp_lo");
		rdchk(6'h14, 16'hffff, "vcc_hi");
		`CHK("irq", 1'b0, irq)
		`CHK("hiz", 1'b1, hiz)
		`CHK("out_b", 1'b0, oeb)
	endtask
	task automatic t_conv;
		int g;
		lat <= 4'd9;
		pollst(16'h000f);
		for (int i = 0; i < 4; i++) begin
			rdchk(6'(i * 4), vals[i * 16 +: 16] & 16'hfff0, "result");
		end
		nextst(g);
		for (int i = 0; i < 4; i++) begin
			c = ch;
			nextst(g);
			`CHK("gap", 100, g)
			`CHK("chan", c + 2'd1, ch)
		end
		lat <= 4'd1;
	endtask
	task automatic t_alarm;
		wb(1, 6'h14, 16'h1000);
		wb(1, 6'h20, 16'h0000);
		wb(1, 6'h2c, 16'hffff);
		pollst(16'h000f);
		`CHK("flags", 8'h12, rd[11:4])
		wb(1, 6'h3c, 16'h0020);
		repeat (3) @(posedge clk_i);
		`CHK("irq_on", 1'b1, irq)
		wb(1, 6'h3c, 16'h0010);
		repeat (3) @(posedge clk_i);
		`CHK("irq_mask", 1'b0, irq)
		hold <= 1;
		repeat (5) @(posedge clk_i);
		wb(1, 6'h2c, 16'hffff);
		rdchk(6'h38, 16'h0, "cleared");
		wb(1, 6'h3c, 16'h0fff);
		repeat (3) @(posedge clk_i);
		`CHK("irq_clr", 1'b0, irq)
		hold <= 0;
		pollst(16'h0020);
		wb(1, 6'h30, 16'h0004);
		repeat (3) @(posedge clk_i);
		`CHK("out_a_alarm", 1'b0, oea)
		wb(1, 6'h30, 16'h0000);
		repeat (3) @(posedge clk_i);
		`CHK("out_a", 1'b1, oea)
	endtask
	task automatic t_res;
		rz <= 0;
		pa <= 0;
		pb <= 1;
		repeat (12) @(posedge clk_i);
		`CHK("hiz_off", 1'b0, hiz)
		`CHK("out_a_low", 1'b0, oea)
		`CHK("out_b_high", 1'b1, oeb)
		wb(1, 6'h34, 16'h5aa5);
		repeat (3) @(posedge clk_i);
		`CHK("res0_man", 8'ha5, r0)
		`CHK("res1_man", 8'h5a, r1)
		wb(1, 6'h30, 16'h0001);
		wb(1, 6'h2c, 16'hffff);
		pollst(16'h0001);
		repeat (3) @(posedge clk_i);
		`CHK("lut_addr", 8'h8f, la)
		`CHK("res0_lut", 8'h8f, r0)
		`CHK("res1_lut", 8'h70, r1)
		wb(1, 6'h30, 16'h0002);
		wb(1, 6'h34, 16'h1234);
		rdchk(6'h34, 16'h5aa5, "locked");
		wp <= 0;
		repeat (12) @(posedge clk_i);
		wb(1, 6'h34, 16'h1234);
		rdchk(6'h34, 16'h1234, "unlocked");
		sel <= 4'h1;
		wb(1, 6'h34, 16'h4321);
		sel <= 4'hf;
		rdchk(6'h34, 16'h1234, "sel_refused");
		wb(1, 6'h00, 16'hffff);
		rdchk(6'h00, 16'hf600, "ro_result");
	endtask
	task automatic conclude;
		$display("checks %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		repeat (8) @(posedge clk_i);
		t_reset;
		t_conv;
		t_alarm;
		t_res;
		conclude;
	end
	// whole run needs a few thousand cycles
	initial begin
		#200000;
		miscompares++;
		conclude;
	end
endmodule
`default_nettype wire
